// file: rsx_byte_unit.sv
`timescale 1ns/10ps
`include "rsx_map.svh"
module rsx_byte_unit #(
	parameter int WIDTH = 8
) (
	input wire logic [WIDTH-1:0] mem_byte,
	input wire logic link_in,
	input wire logic [2:0] bit_sel,
	output logic [WIDTH-1:0] rot_right,
	output logic [WIDTH-1:0] rot_right_link,
	output logic [WIDTH-1:0] rot_left_link,
	output logic [WIDTH-1:0] swapped,
	output logic [WIDTH-1:0] plus_one,
	output logic [WIDTH-1:0] minus_one,
	output logic [WIDTH-1:0] bit_forced,
	output logic bit_hit
);
	// ****************************************************************
	// rotates and nibble swap
	// ****************************************************************
	assign rot_right = {mem_byte[0], mem_byte[WIDTH-1:1]};
	assign rot_right_link = {link_in, mem_byte[WIDTH-1:1]};
	assign rot_left_link = {mem_byte[WIDTH-2:0], link_in};
	assign swapped = {mem_byte[WIDTH/2-1:0], mem_byte[WIDTH-1:WIDTH/2]};

	// wrap-around step by one
	assign plus_one = mem_byte + WIDTH'(1);
	assign minus_one = mem_byte - WIDTH'(1);
	assign bit_hit = mem_byte[bit_sel];

	// ****************************************************************
	// single bit set, other bits kept
	// ****************************************************************
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		assign bit_forced[i] = mem_byte[i] | (bit_sel == 3'(i));
	end
endmodule

// file: rsx_exec.sv
`timescale 1ns/10ps
`include "rsx_map.svh"
module rsx_exec (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic issue,
	input wire rsx_pkg::rsx_op_t op,
	input wire logic [7:0] mem_rd_data,
	input wire logic [7:0] imm_data,
	input wire logic [2:0] bit_sel,
	output logic ready,
	output logic instr_done,
	output logic dummy_slot,
	output logic discard_fetch,
	output logic mem_wr_en,
	output logic [7:0] mem_wr_data,
	output logic [7:0] working_register,
	output logic link_flag,
	output logic signed_wrap_flag,
	output logic null_outcome_flag,
	output logic nibble_link_flag,
	output logic sign_outcome_flag,
	output logic borrow_zero_flag
);
	// sequencer state; take marks a request accepted on this edge
	rsx_pkg::rsx_state_t state;
	rsx_pkg::rsx_state_t next_state;
	logic take;

	// ****************************************************************
	// operation decode
	// ****************************************************************
	// decode wires, one per code; unused codes leave all of them low
	logic is_rotl_link_work;
	logic is_rotr_mem;
	logic is_rotr_work;
	logic is_rotr_link_mem;
	logic is_rotr_link_work;
	logic is_sbc_mem;
	logic is_sbc_imm;
	logic is_sbc_to_mem;
	logic is_sub_mem;
	logic is_sub_to_mem;
	logic is_sub_imm;
	logic is_dec_mem;
	logic is_dec_work;
	logic is_inc_mem;
	logic is_inc_work;
	logic is_set_byte;
	logic is_set_bit;
	logic is_nz_bit;
	logic is_nz_byte;
	logic is_null_byte;
	logic is_swap_mem;
	logic is_swap_work;

	// one named wire per operation
	assign take = issue & ready;
	assign is_rotl_link_work = (op == rsx_pkg::RSX_OP_ROTL_LINK_TO_WORK);
	assign is_rotr_mem = (op == rsx_pkg::RSX_OP_ROTATE_RIGHT_MEM);
	assign is_rotr_work = (op == rsx_pkg::RSX_OP_ROTATE_RIGHT_TO_WORK);
	assign is_rotr_link_mem = (op == rsx_pkg::RSX_OP_ROTATE_RIGHT_LINK_MEM);
	assign is_rotr_link_work = (op == rsx_pkg::RSX_OP_ROTATE_RIGHT_LINK_TO_WORK);
	assign is_sbc_mem = (op == rsx_pkg::RSX_OP_SUBTRACT_WITH_BORROW);
	assign is_sbc_imm = (op == rsx_pkg::RSX_OP_SUBTRACT_WITH_BORROW_IMM);
	assign is_sbc_to_mem = (op == rsx_pkg::RSX_OP_SUBTRACT_BORROW_TO_MEM);
	assign is_sub_mem = (op == rsx_pkg::RSX_OP_SUBTRACT_PLAIN);
	assign is_sub_to_mem = (op == rsx_pkg::RSX_OP_SUBTRACT_PLAIN_TO_MEM);
	assign is_sub_imm = (op == rsx_pkg::RSX_OP_SUBTRACT_PLAIN_IMM);
	assign is_dec_mem = (op == rsx_pkg::RSX_OP_DECREMENT_SKIP_ZERO);
	assign is_dec_work = (op == rsx_pkg::RSX_OP_DECREMENT_SKIP_ZERO_WORK);
	assign is_inc_mem = (op == rsx_pkg::RSX_OP_INCREMENT_SKIP_ZERO);
	assign is_inc_work = (op == rsx_pkg::RSX_OP_INCREMENT_SKIP_ZERO_WORK);
	assign is_set_byte = (op == rsx_pkg::RSX_OP_SET_BYTE);
	assign is_set_bit = (op == rsx_pkg::RSX_OP_SET_BIT);
	assign is_nz_bit = (op == rsx_pkg::RSX_OP_SKIP_IF_NONZERO_BIT);
	assign is_nz_byte = (op == rsx_pkg::RSX_OP_SKIP_IF_NONZERO);
	assign is_null_byte = (op == rsx_pkg::RSX_OP_SKIP_IF_NULL);
	assign is_swap_mem = (op == rsx_pkg::RSX_OP_SWAP_MEM);
	assign is_swap_work = (op == rsx_pkg::RSX_OP_NIBBLE_EXCHANGE_WORK);

	// ****************************************************************
	// operation groups
	// ****************************************************************
	logic any_sub;
	logic sub_borrow;
	logic sub_imm;
	logic any_skip;
	logic rot_link;

	// group membership steers the shared datapath
	assign sub_borrow = is_sbc_mem | is_sbc_imm | is_sbc_to_mem;
	assign sub_imm = is_sbc_imm | is_sub_imm;
	assign any_sub = sub_borrow
		| is_sub_mem
		| is_sub_to_mem
		| is_sub_imm;
	assign rot_link = is_rotl_link_work
		| is_rotr_link_mem
		| is_rotr_link_work;
	// every skip op takes the dummy cycle, whether the skip is taken or not
	assign any_skip = is_dec_mem
		| is_dec_work
		| is_inc_mem
		| is_inc_work
		| is_nz_bit
		| is_nz_byte
		| is_null_byte;

	// ****************************************************************
	// datapath units
	// ****************************************************************
	logic [7:0] sub_operand;
	logic [7:0] sub_diff;
	logic sub_no_borrow;
	logic sub_nibble;
	logic sub_wrap;
	logic sub_zero;
	logic sub_sign;
	logic sub_bz;
	logic [7:0] rot_right;
	logic [7:0] rot_right_link;
	logic [7:0] rot_left_link;
	logic [7:0] swapped;
	logic [7:0] plus_one;
	logic [7:0] minus_one;
	logic [7:0] bit_forced;
	logic bit_hit;

	// immediate or memory byte as subtrahend
	assign sub_operand = sub_imm ? imm_data : mem_rd_data;

	// stored link feeds the borrow forms, so multi-byte subtracts chain
	rsx_sub_unit u_sub (
		.minuend(working_register),
		.subtrahend(sub_operand),
		.link_in(link_flag),
		.use_borrow(sub_borrow),
		.old_borrow_zero(borrow_zero_flag),
		.diff(sub_diff),
		.no_borrow(sub_no_borrow),
		.nibble_carry(sub_nibble),
		.wrap(sub_wrap),
		.zero(sub_zero),
		.sign(sub_sign),
		.borrow_zero(sub_bz)
	);

	// byte unit sees the memory byte alone; link enters only the rotates
	rsx_byte_unit #(
		.WIDTH(8)
	) u_byte (
		.mem_byte(mem_rd_data),
		.link_in(link_flag),
		.bit_sel(bit_sel),
		.rot_right(rot_right),
		.rot_right_link(rot_right_link),
		.rot_left_link(rot_left_link),
		.swapped(swapped),
		.plus_one(plus_one),
		.minus_one(minus_one),
		.bit_forced(bit_forced),
		.bit_hit(bit_hit)
	);

	// ****************************************************************
	// result selection
	// ****************************************************************
	logic to_work;
	logic to_mem;
	logic [7:0] result;
	logic skip_cond;
	logic link_from_rot;
	logic new_link;

	// destination of each operation
	assign to_work = is_rotl_link_work
		| is_rotr_work
		| is_rotr_link_work
		| is_sbc_mem
		| is_sbc_imm
		| is_sub_mem
		| is_sub_imm
		| is_dec_work
		| is_inc_work
		| is_swap_work;
	// byte tests write back too, so a memory watcher still sees a store
	assign to_mem = is_rotr_mem
		| is_rotr_link_mem
		| is_sbc_to_mem
		| is_sub_to_mem
		| is_dec_mem
		| is_inc_mem
		| is_set_byte
		| is_set_bit
		| is_nz_byte
		| is_null_byte
		| is_swap_mem;

	// single result byte shared by both destinations
	always_comb begin
		result = mem_rd_data; // byte tests write the byte back unchanged
		if (is_rotl_link_work) begin
			result = rot_left_link;
		end else if (is_rotr_mem | is_rotr_work) begin
			result = rot_right;
		end else if (is_rotr_link_mem | is_rotr_link_work) begin
			result = rot_right_link;
		end else if (any_sub) begin
			result = sub_diff;
		end else if (is_dec_mem | is_dec_work) begin
			result = minus_one;
		end else if (is_inc_mem | is_inc_work) begin
			result = plus_one;
		end else if (is_set_byte) begin
			result = `RSX_BYTE_ONES;
		end else if (is_set_bit) begin
			result = bit_forced;
		end else if (is_swap_mem | is_swap_work) begin
			result = swapped;
		end
	end

	// skip condition, tested on the result byte
	// step ops test the new value, byte tests the value as read
	always_comb begin
		skip_cond = 1'b0;
		if (is_dec_mem | is_dec_work | is_inc_mem | is_inc_work) begin
			skip_cond = (result == `RSX_BYTE_ZERO);
		end else if (is_nz_bit) begin
			skip_cond = bit_hit;
		end else if (is_nz_byte) begin
			skip_cond = (mem_rd_data != `RSX_BYTE_ZERO);
		end else if (is_null_byte) begin
			skip_cond = (mem_rd_data == `RSX_BYTE_ZERO);
		end
	end

	// link out of the nine-bit rotates
	assign link_from_rot = is_rotl_link_work ? mem_rd_data[`RSX_MSB] : mem_rd_data[`RSX_LSB];
	assign new_link = any_sub ? sub_no_borrow : link_from_rot;

	// ****************************************************************
	// sequencer: one cycle, or two for skip operations
	// ****************************************************************
	// a request in the dummy cycle is not taken; ready is low there to show it
	assign ready = (state == rsx_pkg::RSX_ST_IDLE);

	// next state: a taken skip op buys exactly one dummy cycle
	always_comb begin
		case (state)
			rsx_pkg::RSX_ST_IDLE: begin
				next_state = (take & any_skip) ? rsx_pkg::RSX_ST_DUMMY : rsx_pkg::RSX_ST_IDLE;
			end
			rsx_pkg::RSX_ST_DUMMY: begin
				next_state = rsx_pkg::RSX_ST_IDLE;
			end
			default: begin
				next_state = rsx_pkg::RSX_ST_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state <= rsx_pkg::RSX_ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************************************
	// dummy slot and fetch discard
	// ****************************************************************
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			dummy_slot <= 1'b0;
			discard_fetch <= 1'b0;
		end else begin
			dummy_slot <= take & any_skip;
			discard_fetch <= take & any_skip & skip_cond;
		end
	end

	// done pulses at the end of the last instruction cycle
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			instr_done <= 1'b0;
		end else begin
			instr_done <= (take & ~any_skip) | (state == rsx_pkg::RSX_ST_DUMMY);
		end
	end

	// ****************************************************************
	// memory write port
	// ****************************************************************
	// data holds its last value between writes; the enable is a pulse
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			mem_wr_en <= 1'b0;
			mem_wr_data <= `RSX_BYTE_ZERO;
		end else begin
			mem_wr_en <= take & to_mem;
			if (take & to_mem) begin
				mem_wr_data <= result;
			end
		end
	end

	// ****************************************************************
	// working register
	// ****************************************************************
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			working_register <= `RSX_WORK_RESET;
		end else if (take & to_work) begin
			working_register <= result;
		end
	end

	// ****************************************************************
	// status flags: only subtracts and link rotates touch them
	// ****************************************************************
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			link_flag <= `RSX_FLAG_RESET;
		end else if (take & (any_sub | rot_link)) begin
			link_flag <= new_link;
		end
	end

	// arithmetic flags change on subtracts alone
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			signed_wrap_flag <= `RSX_FLAG_RESET;
			null_outcome_flag <= `RSX_FLAG_RESET;
			nibble_link_flag <= `RSX_FLAG_RESET;
			sign_outcome_flag <= `RSX_FLAG_RESET;
			borrow_zero_flag <= `RSX_FLAG_RESET;
		end else if (take & any_sub) begin
			signed_wrap_flag <= sub_wrap;
			null_outcome_flag <= sub_zero;
			nibble_link_flag <= sub_nibble;
			sign_outcome_flag <= sub_sign;
			borrow_zero_flag <= sub_bz;
		end
	end
endmodule

// file: rsx_exec_asserts.sv
`timescale 1ns/10ps
// ****************************************************************
// port checker for the execution block
// ****************************************************************
module rsx_exec_chk (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic issue,
	input wire rsx_pkg::rsx_op_t op,
	input wire logic [7:0] mem_rd_data,
	input wire logic [7:0] imm_data,
	input wire logic ready,
	input wire logic instr_done,
	input wire logic dummy_slot,
	input wire logic discard_fetch,
	input wire logic mem_wr_en,
	input wire logic [7:0] mem_wr_data,
	input wire logic [7:0] working_register,
	input wire logic link_flag,
	input wire logic signed_wrap_flag,
	input wire logic null_outcome_flag
);
	// taken request, op classes and expected byte shapes
	wire logic tk = issue && ready;
	wire logic skp = op inside {[5'h0c:5'h0f], [5'h12:5'h14]};
	wire logic keep = op inside {[5'h01:5'h05], [5'h0c:5'h16]};
	wire logic to_work = op inside {5'h01, 5'h03, 5'h05, 5'h0d, 5'h0f, 5'h16};
	wire logic [7:0] rr = {mem_rd_data[0], mem_rd_data[7:1]};
	wire logic [7:0] sw = {mem_rd_data[3:0], mem_rd_data[7:4]};
	wire logic [7:0] dif = working_register - imm_data;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	a_skip_dummy_slot: assert property (tk && skp
		|=> dummy_slot && !ready && !instr_done) else $error("skip op did not enter its dummy cycle");
	a_skip_done_two: assert property (dummy_slot |=> instr_done && !dummy_slot)
		else $error("skip op did not end in its second cycle");
	a_plain_done_one: assert property (tk && !skp |=> instr_done && !dummy_slot)
		else $error("plain op did not end in one cycle");
	a_discard_in_dummy: assert property (discard_fetch |-> dummy_slot)
		else $error("discard outside the dummy cycle");
	a_rotr_mem_data: assert property (tk && op == rsx_pkg::RSX_OP_ROTATE_RIGHT_MEM
		|=> mem_wr_en && mem_wr_data == $past(rr)) else $error("right rotate write wrong");
	a_swap_mem_data: assert property (tk && op == rsx_pkg::RSX_OP_SWAP_MEM
		|=> mem_wr_en && mem_wr_data == $past(sw)) else $error("nibble swap write wrong");
	a_work_no_write: assert property (tk && to_work |=> !mem_wr_en)
		else $error("work destination op wrote memory");
	a_set_byte_ones: assert property (tk && op == rsx_pkg::RSX_OP_SET_BYTE
		|=> mem_wr_en && mem_wr_data == 8'hff) else $error("byte set write wrong");
	a_flags_kept: assert property (tk && keep
		|=> $stable(signed_wrap_flag) && $stable(null_outcome_flag)) else $error("flags moved");
	a_sub_imm_work: assert property (tk && op == rsx_pkg::RSX_OP_SUBTRACT_PLAIN_IMM
		|=> working_register == $past(dif)) else $error("immediate subtract wrong");
	a_dec_skip_zero: assert property (tk && op == rsx_pkg::RSX_OP_DECREMENT_SKIP_ZERO
		&& mem_rd_data == 8'h01 |=> discard_fetch && mem_wr_data == 8'h00)
		else $error("decrement to zero did not skip");
	a_sub_borrow_link: assert property (tk && op == rsx_pkg::RSX_OP_SUBTRACT_PLAIN
		&& mem_rd_data > working_register |=> !link_flag) else $error("borrow left link set");

	c_skip_taken: cover property (tk && skp ##1 discard_fetch);
	c_skip_passed: cover property (dummy_slot && !discard_fetch);
	c_sub_to_mem: cover property (tk && op == rsx_pkg::RSX_OP_SUBTRACT_BORROW_TO_MEM);
endmodule
bind rsx_exec rsx_exec_chk u_chk (.*);

// file: rsx_exec_tb.sv
`timescale 1ns/10ps
module rsx_exec_tb;
	// ****************************************************************
	// stimulus, observed ports and tracked state
	// ****************************************************************
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic issue = 1'b0;
	rsx_pkg::rsx_op_t op = rsx_pkg::RSX_OP_NONE;
	logic [7:0] mem_rd_data = 8'h00;
	logic [7:0] imm_data = 8'h00;
	logic [2:0] bit_sel = 3'h0;
	logic ready, instr_done, dummy_slot, discard_fetch, mem_wr_en;
	logic [7:0] mem_wr_data, working_register;
	logic link_flag, signed_wrap_flag, null_outcome_flag;
	logic nibble_link_flag, sign_outcome_flag, borrow_zero_flag;
	logic [7:0] w;
	logic l, bz;
	int err_total = 0;
	int checks = 0;
	wire logic [4:0] fl = {signed_wrap_flag, null_outcome_flag, nibble_link_flag,
		sign_outcome_flag, borrow_zero_flag};

	rsx_exec dut (.*);

	// free running clock
	always #25 ref_clk = ~ref_clk;

	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		checks++;
		if (s !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// present one request at the falling edge; it is taken at the next rising edge
	task automatic go(input rsx_pkg::rsx_op_t o, input logic [7:0] m, input logic [7:0] i,
		input logic [2:0] b);
		op = o;
		mem_rd_data = m;
		imm_data = i;
		bit_sel = b;
		issue = 1'b1;
		@(negedge ref_clk);
	endtask

	task automatic res(input logic e, input logic [7:0] d, input logic [7:0] wv, input logic lv);
		chk("mem_wr_en", mem_wr_en, e);
		if (e) chk("mem_wr_data", mem_wr_data, d);
		chk("working_register", working_register, wv);
		chk("link_flag", link_flag, lv);
	endtask

	task automatic step(input rsx_pkg::rsx_op_t o, input logic [7:0] m, input logic [2:0] b,
		input logic e, input logic [7:0] d, input logic [7:0] wv, input logic lv);
		go(o, m, 8'h00, b);
		res(e, d, wv, lv);
	endtask

	task automatic s_reset();
		issue = 1'b0;
		nrst = 1'b0;
		repeat (20) @(negedge ref_clk);
		chk("reset ready", ready, 8'h01);
		chk("reset work", working_register, 8'h00);
		chk("reset flags", {fl, link_flag, dummy_slot, discard_fetch}, 8'h00);
		chk("reset pulses", {mem_wr_en, instr_done}, 8'h00);
		nrst = 1'b1;
		w = 8'h00;
		l = 1'b0;
		bz = 1'b0;
		@(negedge ref_clk);
	endtask

	// rotates, swap, set and an unused code, back to back
	task automatic s_rot();
		logic [4:0] f;
		step(rsx_pkg::RSX_OP_SUBTRACT_PLAIN_IMM, 8'h00, 3'h0, 1'b0, 8'h00, w, 1'b1);
		f = fl;
		step(rsx_pkg::RSX_OP_ROTL_LINK_TO_WORK, 8'h81, 3'h0, 1'b0, 8'h00, 8'h03, 1'b1);
		step(rsx_pkg::RSX_OP_ROTATE_RIGHT_LINK_TO_WORK, 8'h02, 3'h0,
			1'b0, 8'h00, 8'h81, 1'b0);
		step(rsx_pkg::RSX_OP_ROTATE_RIGHT_LINK_MEM, 8'h01, 3'h0, 1'b1, 8'h00, 8'h81, 1'b1);
		step(rsx_pkg::RSX_OP_ROTATE_RIGHT_MEM, 8'h01, 3'h0, 1'b1, 8'h80, 8'h81, 1'b1);
		step(rsx_pkg::RSX_OP_ROTATE_RIGHT_TO_WORK, 8'h06, 3'h0, 1'b0, 8'h00, 8'h03, 1'b1);
		step(rsx_pkg::RSX_OP_SWAP_MEM, 8'h3c, 3'h0, 1'b1, 8'hc3, 8'h03, 1'b1);
		step(rsx_pkg::RSX_OP_NIBBLE_EXCHANGE_WORK, 8'h5a, 3'h0, 1'b0, 8'h00, 8'ha5, 1'b1);
		step(rsx_pkg::RSX_OP_SET_BYTE, 8'h12, 3'h0, 1'b1, 8'hff, 8'ha5, 1'b1);
		step(rsx_pkg::RSX_OP_SET_BIT, 8'h41, 3'h5, 1'b1, 8'h61, 8'ha5, 1'b1);
		step(rsx_pkg::RSX_OP_NONE, 8'h00, 3'h0, 1'b0, 8'h00, 8'ha5, 1'b1);
		chk("kept flags", fl, f);
		w = 8'ha5;
		l = 1'b1;
		bz = 1'b1;
	endtask

	// all six subtract forms twice, with borrow, overflow and zero results
	task automatic s_sub();
		rsx_pkg::rsx_op_t o;
		logic [7:0] b, r;
		logic [8:0] t;
		logic [4:0] h;
		logic c, ov, z, bf, im, mf;
		for (int k = 0; k < 12; k++) begin
			o = rsx_pkg::rsx_op_t'(5'h06 + 5'(k % 6));
			bf = (k % 6) < 3;
			im = (k % 6) == 1 || (k % 6) == 5;
			mf = (k % 6) == 2 || (k % 6) == 4;
			b = (k == 5) ? w : 8'h7f + 8'(k) * 8'h29;
			c = bf ? ~l : 1'b0;
			t = {1'b0, w} - {1'b0, b} - 9'(c);
			h = {1'b0, w[3:0]} - {1'b0, b[3:0]} - 5'(c);
			r = t[7:0];
			ov = (w[7] ^ b[7]) & (w[7] ^ r[7]);
			z = r == 8'h00;
			go(o, im ? ~b : b, b, 3'h0);
			res(mf, r, mf ? w : r, ~t[8]);
			chk("sub flags", fl, {ov, z, ~h[4], ov ^ r[7], bf ? z & bz : z});
			if (!mf) w = r;
			l = ~t[8];
			bz = bf ? z & bz : z;
		end
	endtask

	// skip op: dummy cycle, a refused re-issue inside it, then the end pulse
	task automatic sk(input rsx_pkg::rsx_op_t o, input logic [7:0] m, input logic [2:0] b,
		input logic e, input logic [7:0] d, input logic [7:0] wv, input logic dsc);
		logic [4:0] f;
		f = fl;
		go(o, m, 8'h00, b);
		chk("skip slot", {ready, dummy_slot, instr_done, discard_fetch}, {3'b010, dsc});
		res(e, d, wv, l);
		@(negedge ref_clk);
		chk("skip end", {ready, dummy_slot, instr_done, mem_wr_en}, 8'h0a);
		chk("skip flags", fl, f);
	endtask

	task automatic s_skip();
		sk(rsx_pkg::RSX_OP_DECREMENT_SKIP_ZERO, 8'h01, 3'h0, 1'b1, 8'h00, w, 1'b1);
		sk(rsx_pkg::RSX_OP_DECREMENT_SKIP_ZERO, 8'h00, 3'h0, 1'b1, 8'hff, w, 1'b0);
		sk(rsx_pkg::RSX_OP_DECREMENT_SKIP_ZERO_WORK,
			8'h02, 3'h0, 1'b0, 8'h00, 8'h01, 1'b0);
		sk(rsx_pkg::RSX_OP_DECREMENT_SKIP_ZERO_WORK,
			8'h01, 3'h0, 1'b0, 8'h00, 8'h00, 1'b1);
		sk(rsx_pkg::RSX_OP_INCREMENT_SKIP_ZERO, 8'hff, 3'h0, 1'b1, 8'h00, 8'h00, 1'b1);
		sk(rsx_pkg::RSX_OP_INCREMENT_SKIP_ZERO_WORK,
			8'h10, 3'h0, 1'b0, 8'h00, 8'h11, 1'b0);
		sk(rsx_pkg::RSX_OP_INCREMENT_SKIP_ZERO_WORK,
			8'hff, 3'h0, 1'b0, 8'h00, 8'h00, 1'b1);
		sk(rsx_pkg::RSX_OP_SKIP_IF_NONZERO_BIT, 8'h08, 3'h3, 1'b0, 8'h00, 8'h00, 1'b1);
		sk(rsx_pkg::RSX_OP_SKIP_IF_NONZERO_BIT, 8'hf7, 3'h3, 1'b0, 8'h00, 8'h00, 1'b0);
		sk(rsx_pkg::RSX_OP_SKIP_IF_NONZERO, 8'h00, 3'h0, 1'b1, 8'h00, 8'h00, 1'b0);
		sk(rsx_pkg::RSX_OP_SKIP_IF_NONZERO, 8'h42, 3'h0, 1'b1, 8'h42, 8'h00, 1'b1);
		sk(rsx_pkg::RSX_OP_SKIP_IF_NULL, 8'h00, 3'h0, 1'b1, 8'h00, 8'h00, 1'b1);
		sk(rsx_pkg::RSX_OP_SKIP_IF_NULL, 8'h81, 3'h0, 1'b1, 8'h81, 8'h00, 1'b0);
		issue = 1'b0;
	endtask

	// main sequence, with a second reset in mid-run
	initial begin
		s_reset();
		s_rot();
		s_sub();
		s_reset();
		s_skip();
		conclude();
	end

	// watchdog well beyond the roughly 90 cycles the sequence needs
	initial begin
		repeat (2000) @(posedge ref_clk);
		err_total++;
		conclude();
	end
endmodule

// file: rsx_map.svh
`ifndef RSX_MAP_SVH
`define RSX_MAP_SVH

// ****************************************************************
// reset values and constants
// ****************************************************************
`define RSX_WORK_RESET 8'h00
`define RSX_FLAG_RESET 1'b0
`define RSX_BYTE_ONES 8'hff
`define RSX_BYTE_ZERO 8'h00
`define RSX_BYTE_ONE 8'h01
`define RSX_MSB 7
`define RSX_LSB 0
`define RSX_NIB_LO_TOP 3
`define RSX_NIB_HI_BOT 4
`define RSX_SKIP_CYCLES 2
`endif

// file: rsx_pkg.sv
package rsx_pkg;
	// ****************************************************************
	// operation codes
	// ****************************************************************
	typedef enum logic [4:0] {
		RSX_OP_NONE = 5'b00000,
		RSX_OP_ROTL_LINK_TO_WORK = 5'b00001,
		RSX_OP_ROTATE_RIGHT_MEM = 5'b00010,
		RSX_OP_ROTATE_RIGHT_TO_WORK = 5'b00011,
		RSX_OP_ROTATE_RIGHT_LINK_MEM = 5'b00100,
		RSX_OP_ROTATE_RIGHT_LINK_TO_WORK = 5'b00101,
		RSX_OP_SUBTRACT_WITH_BORROW = 5'b00110,
		RSX_OP_SUBTRACT_WITH_BORROW_IMM = 5'b00111,
		RSX_OP_SUBTRACT_BORROW_TO_MEM = 5'b01000,
		RSX_OP_SUBTRACT_PLAIN = 5'b01001,
		RSX_OP_SUBTRACT_PLAIN_TO_MEM = 5'b01010,
		RSX_OP_SUBTRACT_PLAIN_IMM = 5'b01011,
		RSX_OP_DECREMENT_SKIP_ZERO = 5'b01100,
		RSX_OP_DECREMENT_SKIP_ZERO_WORK = 5'b01101,
		RSX_OP_INCREMENT_SKIP_ZERO = 5'b01110,
		RSX_OP_INCREMENT_SKIP_ZERO_WORK = 5'b01111,
		RSX_OP_SET_BYTE = 5'b10000,
		RSX_OP_SET_BIT = 5'b10001,
		RSX_OP_SKIP_IF_NONZERO_BIT = 5'b10010,
		RSX_OP_SKIP_IF_NONZERO = 5'b10011,
		RSX_OP_SKIP_IF_NULL = 5'b10100,
		RSX_OP_SWAP_MEM = 5'b10101,
		RSX_OP_NIBBLE_EXCHANGE_WORK = 5'b10110
	} rsx_op_t;

	// ****************************************************************
	// sequencer states
	// ****************************************************************
	typedef enum logic [0:0] {
		RSX_ST_IDLE = 1'b0,
		RSX_ST_DUMMY = 1'b1
	} rsx_state_t;
endpackage

// file: rsx_sub_unit.sv
`timescale 1ns/10ps
`include "rsx_map.svh"
module rsx_sub_unit (
	input wire logic [7:0] minuend,
	input wire logic [7:0] subtrahend,
	input wire logic link_in,
	input wire logic use_borrow,
	input wire logic old_borrow_zero,
	output logic [7:0] diff,
	output logic no_borrow,
	output logic nibble_carry,
	output logic wrap,
	output logic zero,
	output logic sign,
	output logic borrow_zero
);
	logic carry_in;
	logic [8:0] full_sum;
	logic [4:0] low_sum;

	// ****************************************************************
	// two's complement subtract: a + ~b + carry
	// ****************************************************************
	assign carry_in = use_borrow ? link_in : 1'b1;
	assign full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + {8'h00, carry_in};
	assign low_sum = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, carry_in};
	assign diff = full_sum[7:0];

	// flag terms, carry out set means no borrow
	assign no_borrow = full_sum[8];
	assign nibble_carry = low_sum[4];
	assign wrap = (minuend[`RSX_MSB] != subtrahend[`RSX_MSB])
		& (full_sum[`RSX_MSB] != minuend[`RSX_MSB]);
	assign zero = (full_sum[7:0] == `RSX_BYTE_ZERO);
	assign sign = wrap ^ full_sum[`RSX_MSB]; // sign of the true result
	assign borrow_zero = use_borrow ? (zero & old_borrow_zero) : zero; // chained zero
endmodule
